// file: logic/tgb_master.sv
// Telegram bus master: register port, FIFOs, bit timing, flags.
// Assumes the bus pin is open drain with an external pull-up.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Flip-flop FIFO, depth a power of two
module tgb_fifo #(
  parameter int W = 13,
  parameter int D = 4
) (
  // Clock and clear
  input  wire logic         clk,
  input  wire logic         clr,
  // Fill side
  input  wire logic         push,
  input  wire logic [W-1:0] din,
  output logic              full,
  // Drain side
  input  wire logic         pop,
  output logic [W-1:0]      dout,
  output logic              empty
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_r [D];  // Storage
  logic [AW-1:0] wp_r;       // Write index
  logic [AW-1:0] rp_r;       // Read index
  logic [AW:0]   n_r;        // Fill level
  wire           do_push;
  wire           do_pop;

  // Refuse push when full, pop when empty
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign full    = (n_r == (AW+1)'(D));
  assign empty   = (n_r == '0);
  assign dout    = mem_r[rp_r];

  // Storage write
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_r[wp_r] <= din;
    end
  end

  // Pointers and level
  always_ff @(posedge clk) begin
    if (clr) begin
      wp_r <= '0;
      rp_r <= '0;
      n_r  <= '0;
    end else begin
      wp_r <= wp_r + {{(AW-1){1'b0}}, do_push};
      rp_r <= rp_r + {{(AW-1){1'b0}}, do_pop};
      n_r  <= n_r + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
// Top level
module tgb_master #(
  parameter int RX_DEPTH = 4,
  parameter int TX_DEPTH = 4
) (
  // Clock and resets
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       standby,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // Bus pin
  input  wire logic       bus_in,
  output logic            bus_out,
  output logic            bus_oe_n,
  // Interrupt
  output logic            int_src,
  output logic            int_req
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] ctrl0_r, ctrl1_r;        // Control registers
  logic       rdl_r, tgv_r, pv_r;      // Status flags
  logic       err_r, arb_r;            // Error flags
  logic [5:0] pw_r;                    // Pulse width
  logic       bus_m_r, bus_s_r;        // Pin synchroniser
  logic       bus_d_r;                 // Previous level
  logic [7:0] pre_r;                   // Step prescaler
  logic [5:0] cnt_r;                   // Bit-time counter
  logic [6:0] idle_r;                  // Steps since edge
  logic [1:0] stp_r;                   // Previous state
  logic [2:0] trun_r;                  // Consecutive T count
  logic [7:0] rsh_r;                   // Receive shifter
  logic [3:0] rn_r;                    // Bits in shifter
  logic       rtyp_r;                  // Field type latch
  logic [7:0] tsh_r;                   // Transmit shifter
  logic [3:0] tleft_r;                 // Bits left
  logic       ton_r, tbit_r;           // Current bit
  logic       busy_r;                  // Busy flag
  logic [2:0] txlen_r;                 // Pending length code
  logic       oe_n_r;                  // Pin enable
  logic [7:0] rdata_r;                 // Read data
  tgb_pkg::tgb_tx_st_t tst_r;          // Telegram state
  tgb_pkg::tgb_rx_ent_t rxf, rx_ent;   // Receive entries
  tgb_pkg::tgb_tx_ent_t txf, tx_ent;   // Transmit entries
  wire        rx_full, rx_empty, tx_full, tx_empty;

  // Control fields
  wire        run   = ctrl0_r[7];
  wire        bus_clock_generate   = ctrl0_r[6];
  wire        act   = ctrl0_r[5];
  wire        external_only_receive   = ctrl0_r[4];
  wire [2:0]  psc   = ctrl0_r[2:0];
  wire [3:0]  phase = ctrl1_r[3:0];

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  wire wr_c0   = reg_wr && reg_addr == tgb_pkg::A_CTRL0;
  wire wr_c1   = reg_wr && reg_addr == tgb_pkg::A_CTRL1;
  wire wr_s0   = reg_wr && reg_addr == tgb_pkg::A_STAT0;
  wire wr_tl   = reg_wr && reg_addr == tgb_pkg::A_TXLEN;
  wire rd_fld  = reg_rd && reg_addr == tgb_pkg::A_RXFLD;
  wire wr_adr  = reg_wr && (reg_addr == tgb_pkg::A_TXADR || reg_addr == tgb_pkg::A_RXFLD);
  wire wr_fst  = reg_wr && (reg_addr == tgb_pkg::A_TXADR || reg_addr == tgb_pkg::A_TXDAT);
  wire tx_wr   = wr_fst || (reg_wr && (reg_addr == tgb_pkg::A_RXLEN || reg_addr == tgb_pkg::A_RXFLD));
  wire flush   = wr_tl && reg_wdata[6];
  wire run_set = wr_c0 && reg_wdata[7] && !run;
  // Full reset versus internal reset
  wire full_rst = reset || standby;
  wire sr       = full_rst || !run || run_set;

  ////////////////////////////////////////////////////////////////////////
  // Bit timing and symbol detection
  wire       rise    = bus_s_r && !bus_d_r;
  wire       fall    = !bus_s_r && bus_d_r;
  wire [7:0] pre_lim = 8'(({5'h00, psc} + 8'h01) * tgb_pkg::SUB_CYC - 1);
  wire       tick    = pre_r == pre_lim;
  wire [5:0] hi      = cnt_r + {5'h00, tick} - {2'b00, phase}; // Counts the step ending at this edge
  wire       sym_t   = hi >= tgb_pkg::PW_T;
  wire       sym_bit = hi >= tgb_pkg::PW_ONE;
  wire       rx_sym  = fall && act;
  wire       passive = idle_r == tgb_pkg::IDLE_LIM;
  wire [1:0] rstate  = {!passive, bus_s_r};
  wire       pv_set  = rstate != stp_r && (stp_r == tgb_pkg::ST_PH ||
                       rstate == tgb_pkg::ST_PH || rstate == tgb_pkg::ST_PL);
  wire       err_bit = rx_sym && hi < tgb_pkg::PW_MIN;

  ////////////////////////////////////////////////////////////////////////
  // Receive path
  wire       own     = external_only_receive && tst_r == tgb_pkg::TX_FIELD;
  wire       rx_t    = rx_sym && sym_t && !own;
  wire       rx_n    = rx_sym && !sym_t && !own;
  wire       rx_push = (rx_n && rn_r == 4'h8) || (rx_t && rn_r != 4'h0);
  wire       rdl_set = rx_push && rx_full;
  wire       tgv_set = rx_sym && sym_t && trun_r != 3'h0;
  // Entry: end marked on T, partial length only there
  assign rx_ent.field_type_flag = rtyp_r;
  assign rx_ent.eof  = rx_t;
  assign rx_ent.len  = rx_t ? rn_r[2:0] : 3'h0;
  assign rx_ent.data = rsh_r;

  ////////////////////////////////////////////////////////////////////////
  // Transmit path
  wire       col     = act && ton_r && tbit_r && !bus_s_r &&
                       cnt_r >= tgb_pkg::COL_LO && cnt_r <= tgb_pkg::COL_HI;
  wire       tx_push = tx_wr && !arb_r && !tx_full;
  wire       tx_clr  = sr || col || flush;
  wire [3:0] tn      = (txf.len == 3'h0) ? 4'h8 : {1'b0, txf.len};
  wire       start   = !txf.first || (txf.addr ? trun_r >= 3'h4 : trun_r == 3'h1);
  wire       bnd     = rise && act;
  wire       cont    = bnd && tleft_r != 4'h0;
  wire       load    = bnd && tleft_r == 4'h0 && !tx_empty && start;
  wire [5:0] low_at  = tbit_r ? tgb_pkg::TX_LOW1 : tgb_pkg::TX_LOW0;
  wire       drive   = (bus_clock_generate && cnt_r >= tgb_pkg::TX_REL) ||
                       (ton_r && cnt_r >= low_at && cnt_r < tgb_pkg::TX_REL);
  wire       busy_clr = rx_sym && sym_t && tx_empty && tleft_r == 4'h0 && !ton_r;
  // Length code applies to first byte only
  assign tx_ent.addr  = wr_adr;
  assign tx_ent.first = wr_fst;
  assign tx_ent.len   = wr_fst ? txlen_r : 3'h0;
  assign tx_ent.data  = reg_wdata;

  ////////////////////////////////////////////////////////////////////////
  // FIFOs
  tgb_fifo #(.W($bits(tgb_pkg::tgb_rx_ent_t)), .D(RX_DEPTH)) u_rxf (
    .clk   (clk),
    .clr   (sr),
    .push  (rx_push),
    .din   (rx_ent),
    .full  (rx_full),
    .pop   (rd_fld),
    .dout  (rxf),
    .empty (rx_empty)
  );

  tgb_fifo #(.W($bits(tgb_pkg::tgb_tx_ent_t)), .D(TX_DEPTH)) u_txf (
    .clk   (clk),
    .clr   (tx_clr),
    .push  (tx_push),
    .din   (tx_ent),
    .full  (tx_full),
    .pop   (load),
    .dout  (txf),
    .empty (tx_empty)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read mux and interrupt
  wire [7:0] rxlen_b = rx_empty ? {rdl_r, 7'h00} :
                       {rdl_r, 1'b1, rxf.field_type_flag, rxf.eof, 1'b0, rxf.len};
  wire [7:0] rd_mux  =
    reg_addr == tgb_pkg::A_CTRL0 ? ctrl0_r :
    reg_addr == tgb_pkg::A_CTRL1 ? ctrl1_r :
    reg_addr == tgb_pkg::A_STAT0 ? {rdl_r, !rx_empty, !tx_full, tgv_r, pv_r, err_r, 1'b0, arb_r} :
    reg_addr == tgb_pkg::A_RXLEN ? rxlen_b :
    reg_addr == tgb_pkg::A_TXLEN ? {busy_r, tx_empty, 6'h00} :
    reg_addr == tgb_pkg::A_TXADR ? {rstate, pw_r} :
    reg_addr == tgb_pkg::A_RXFLD ? (rx_empty ? 8'h00 : rxf.data) : 8'h00;
  assign int_src = rdl_r || !rx_empty || !tx_full || tgv_r || pv_r;
  assign int_req = ctrl1_r[7] && (rdl_r || (!rx_empty && ctrl1_r[6]) ||
                   (!tx_full && ctrl1_r[5]) || tgv_r || pv_r);
  assign reg_rdata = rdata_r;
  assign bus_out   = 1'b0;
  assign bus_oe_n  = oe_n_r;

  ////////////////////////////////////////////////////////////////////////
  // Registers kept over internal reset
  always_ff @(posedge clk) begin
    if (full_rst) begin
      ctrl0_r <= tgb_pkg::CTRL0_RST;
      ctrl1_r <= tgb_pkg::CTRL1_RST;
    end else begin
      ctrl0_r <= wr_c0 ? reg_wdata : ctrl0_r;
      ctrl1_r <= wr_c1 ? reg_wdata : ctrl1_r;
    end
  end

  // Status flags: set wins over clear
  always_ff @(posedge clk) begin
    if (full_rst) begin
      {rdl_r, tgv_r, pv_r, err_r, arb_r} <= 5'h00;
      pw_r <= 6'h00;
    end else begin
      rdl_r <= rdl_set || (rdl_r && !rd_fld);
      tgv_r <= tgv_set || (tgv_r && !(rx_sym && !sym_t) && !flush &&
               !(wr_s0 && !reg_wdata[4]));
      pv_r  <= (run && pv_set) || (pv_r && !(wr_s0 && !reg_wdata[3]));
      err_r <= col || err_bit || (err_r && !(wr_s0 && !reg_wdata[2]));
      arb_r <= col || (arb_r && !(wr_s0 && !reg_wdata[0]));
      pw_r  <= (fall && !sym_t) ? hi : pw_r;
    end
  end

  // Read data, one cycle after the strobe only
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit logic: passive high after internal reset
  always_ff @(posedge clk) begin
    if (sr) begin
      bus_m_r <= 1'b1;
      bus_s_r <= 1'b1;
      bus_d_r <= 1'b1;
      pre_r   <= 8'h00;
      cnt_r   <= 6'h00;
      idle_r  <= tgb_pkg::IDLE_LIM;
      stp_r   <= tgb_pkg::ST_PH;
      oe_n_r  <= 1'b1;
    end else begin
      bus_m_r <= bus_in;
      bus_s_r <= bus_m_r;
      bus_d_r <= bus_s_r;
      pre_r   <= tick ? 8'h00 : pre_r + 8'h01;
      cnt_r   <= rise ? {2'b00, phase} : cnt_r + {5'h00, tick};
      idle_r  <= (rise || fall) ? 7'h00 : idle_r + {6'h00, tick && !passive};
      stp_r   <= rstate;
      oe_n_r  <= !drive;
    end
  end

  // Receive shifter and field tracking
  always_ff @(posedge clk) begin
    if (sr) begin
      trun_r <= 3'h0;
      rsh_r  <= 8'h00;
      rn_r   <= 4'h0;
      rtyp_r <= 1'b0;
    end else begin
      if (rx_sym) begin
        trun_r <= !sym_t ? 3'h0 : (trun_r == 3'h4 ? trun_r : trun_r + 3'h1);
      end
      if (rx_t) begin
        rn_r <= 4'h0;
      end else if (rx_n) begin
        rsh_r  <= (rn_r == 4'h0 || rn_r == 4'h8) ? {7'h00, sym_bit} : {rsh_r[6:0], sym_bit};
        rn_r   <= (rn_r == 4'h8) ? 4'h1 : rn_r + 4'h1;
        rtyp_r <= (rn_r == 4'h0) ? tgv_r : rtyp_r;
      end
    end
  end

  // Transmitter: loads at a bit boundary once no bits are left
  always_ff @(posedge clk) begin
    if (sr) begin
      tsh_r   <= 8'h00;
      tleft_r <= 4'h0;
      ton_r   <= 1'b0;
      tbit_r  <= 1'b0;
      tst_r   <= tgb_pkg::TX_IDLE;
      busy_r  <= 1'b0;
      txlen_r <= 3'h0;
    end else begin
      busy_r  <= tx_push || (busy_r && !busy_clr);
      txlen_r <= wr_tl ? reg_wdata[2:0] : (tx_push && wr_fst ? 3'h0 : txlen_r);
      if (col) begin
        tleft_r <= 4'h0;
        ton_r   <= 1'b0;
        tst_r   <= tgb_pkg::TX_IDLE;
      end else if (flush) begin
        tleft_r <= 4'h0;
      end else if (cont) begin
        tbit_r  <= tsh_r[3'(tleft_r - 4'h1)];
        tleft_r <= tleft_r - 4'h1;
        ton_r   <= 1'b1;
      end else if (load) begin
        tsh_r   <= txf.data;
        tbit_r  <= txf.data[3'(tn - 4'h1)];
        tleft_r <= tn - 4'h1;
        ton_r   <= 1'b1;
        tst_r   <= tgb_pkg::TX_FIELD;
      end else if (bnd) begin
        ton_r   <= 1'b0;
        tst_r   <= tx_empty ? tgb_pkg::TX_IDLE : tst_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_arb_flush: assert property (@(posedge clk) disable iff (sr)
    col |=> arb_r && tx_empty) else $error("collision did not flush");
  a_arb_block: assert property (@(posedge clk) disable iff (sr)
    arb_r && tx_empty && tx_wr |=> tx_empty) else $error("write taken while arb lost");
  a_int_src: assert property (@(posedge clk) disable iff (reset)
    $rose(tgv_r) |-> int_src) else $error("interrupt source missing");
  a_pw_hold: assert property (@(posedge clk) disable iff (full_rst)
    fall && !sym_t |=> pw_r == $past(hi)) else $error("pulse width not captured");
  a_len_mirror: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == tgb_pkg::A_RXLEN && !rx_empty
    |=> reg_rdata[6] && reg_rdata[2:0] == $past(rxf.len)) else $error("length not mirrored");
  a_rdl_clear: assert property (@(posedge clk) disable iff (full_rst)
    rd_fld && !rdl_set |=> !rdl_r) else $error("data lost not cleared");
  a_nonfinal_len: assert property (@(posedge clk) disable iff (sr)
    rx_push && !rx_ent.eof |-> rx_ent.len == 3'h0) else $error("partial non-final entry");
  a_flush_clear: assert property (@(posedge clk) disable iff (sr)
    flush && !tgv_set |=> !tgv_r && tx_empty) else $error("flush incomplete");
  a_busy_set: assert property (@(posedge clk) disable iff (sr)
    tx_push |=> busy_r [*2]) else $error("busy not set");
  a_empty_reset: assert property (@(posedge clk)
    sr |=> tx_empty && rx_empty && cnt_r == 6'h00) else $error("internal reset incomplete");
  a_master_t: assert property (@(posedge clk) disable iff (sr)
    bus_clock_generate && cnt_r >= tgb_pkg::TX_REL |=> !bus_oe_n) else $error("clock master not driving");
endmodule

`default_nettype wire

// file: pkg/tgb_pkg.sv
// Constants, entry layouts and states of the telegram bus master.
// Assumes one 250 MHz clock and a plain 8-bit register port.
//
// Notes on behaviour
// - Collision sets arbitration lost, flushes transmit FIFO
// - Transmit FIFO writes ignored while arbitration lost
// - Interrupt source ORs five status flags
// - Two-bit receive state: passive/active, low/high
// - Pulse width holds last non-T high time
// - Receive length describes front receive entry
// - Receive field read clears data lost
// - Field type one for address, zero data
// - End-of-field marks last entry of field
// - Length code 1-7 bits, zero means eight
// - Only final entry may be partial
// - Receive field read pops front entry
// - Busy set on write, cleared after T
// - Flush empties FIFO, clears valid, self-clears
// - Empty reads one with no telegram queued
// - Run set resets all but four registers
// - Internal reset empties, zeroes, idles, passive high
// - Clock master drives continuous T symbols
// - Two T symbols set valid, non-T clears
`default_nettype none
package tgb_pkg;

  // Register offsets
  localparam logic [2:0] A_CTRL0 = 3'h0;
  localparam logic [2:0] A_CTRL1 = 3'h1;
  localparam logic [2:0] A_STAT0 = 3'h2;
  localparam logic [2:0] A_RXLEN = 3'h3;
  localparam logic [2:0] A_TXLEN = 3'h4;
  localparam logic [2:0] A_TXADR = 3'h5;
  localparam logic [2:0] A_TXDAT = 3'h6;
  localparam logic [2:0] A_RXFLD = 3'h7;

  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;

  // Time of one 1/64 step at prescaler zero, and its cycle count
  localparam int CLK_NS  = 4;
  localparam int SUB_NS  = 16;
  localparam int SUB_CYC = (SUB_NS + CLK_NS - 1) / CLK_NS;

  // Bit-time positions in 1/64 steps
  localparam logic [5:0] TX_LOW0 = 6'h0F;
  localparam logic [5:0] TX_LOW1 = 6'h1F;
  localparam logic [5:0] TX_REL  = 6'h37;
  localparam logic [5:0] PW_ONE  = 6'h17;
  localparam logic [5:0] PW_T    = 6'h2B;
  localparam logic [5:0] PW_MIN  = 6'h04;
  localparam logic [5:0] COL_LO  = 6'h11;
  localparam logic [5:0] COL_HI  = 6'h1E;
  localparam logic [6:0] IDLE_LIM = 7'h60;

  // Receive states
  localparam logic [1:0] ST_PL = 2'h0;
  localparam logic [1:0] ST_PH = 2'h1;

  // Receive FIFO entry
  typedef struct packed {
    logic       field_type_flag;
    logic       eof;
    logic [2:0] len;
    logic [7:0] data;
  } tgb_rx_ent_t;

  // Transmit FIFO entry
  typedef struct packed {
    logic       addr;
    logic       first;
    logic [2:0] len;
    logic [7:0] data;
  } tgb_tx_ent_t;

  // Transmitter telegram state
  typedef enum logic {TX_IDLE, TX_FIELD} tgb_tx_st_t;

endpackage
`default_nettype wire

// file: dv/tgb_node_model.sv
// Far-side bus node: plays bit symbols onto the shared wired-or line.
// Assumes the line idles high through a pull-up when nobody pulls.
`timescale 1ns/100ps
`default_nettype none
module tgb_node_model #(
  parameter int STEP = 4 // Clock cycles per 1/64 step
) (
  // Clock
  input  wire logic clk,
  // Line pull-down, high pulls the line low
  output logic      pull
);
  initial pull = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Plays '0', '1' or 'T', one bit time each, high from the rise
  task automatic play(input string s);
    int hi;
    for (int i = 0; i < s.len(); i++) begin
      hi = (s[i] == "T") ? int'(tgb_pkg::TX_REL) : (s[i] == "1") ? int'(tgb_pkg::TX_LOW1) : int'(tgb_pkg::TX_LOW0);
      @(posedge clk) pull <= 1'b0;
      repeat (hi * STEP) @(posedge clk);
      pull <= 1'b1;
      repeat ((64 - hi) * STEP - 1) @(posedge clk);
    end
    // Release, the pull-up takes the line high
    @(posedge clk) pull <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/tgb_master_test.sv
// Self-checking bench of the telegram bus master.
// Assumes a node model on the open-drain line and a pull-up.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module tgb_master_test;
  // Design ports and bench state
  logic       clk, reset, standby, reg_wr, reg_rd, bus_in, bus_out;
  logic       bus_oe_n, int_src, int_req, node_pull, rd_d1;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rnd8, m_e, m_m;
  logic [9:0] d10;
  int         n_errors = 0, num_checks = 0, seed = 32'hcd364033, lo, per;
  string      m_nm;
  string      q_nm[$];
  logic [7:0] q_exp[$], q_msk[$];

  tgb_master #(.RX_DEPTH(4), .TX_DEPTH(4)) DUT (
    .clk(clk), .reset(reset), .standby(standby), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
    .int_src(int_src), .int_req(int_req));
  tgb_node_model NODE (.clk(clk), .pull(node_pull));

  // Wired-or line with pull-up
  assign bus_in = !node_pull && (bus_oe_n || bus_out);

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Register write, one strobe cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Register read, expectation noted first
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m, input string nm);
    q_nm.push_back(nm);
    q_exp.push_back(e);
    q_msk.push_back(m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // Waits for the line enable to reach a level, counting cycles
  task automatic wait_oe(input logic v, output int n);
    n = 0;
    while (bus_oe_n !== v && n < 1000) begin
      @(posedge clk);
      n++;
    end
  endtask

  // Bit string, MSB first
  function automatic string bits(input logic [9:0] v);
    string s = "";
    for (int i = 9; i >= 0; i--) s = {s, v[i] ? "1" : "0"};
    return s;
  endfunction

  // Verdict and end of run
  task automatic results();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Monitor: read data stands in the cycle after the strobe
  always @(posedge clk) begin
    rd_d1 <= reg_rd;
    if (rd_d1 === 1'b1 && q_nm.size() > 0) begin
      m_nm = q_nm.pop_front();
      m_e = q_exp.pop_front();
      m_m = q_msk.pop_front();
      `CHK(m_nm, m_e, reg_rdata & m_m)
    end
  end

  // Watchdog
  initial begin
    #(4 * 40000);
    n_errors++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    standby = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    // Reset values
    rd(tgb_pkg::A_CTRL0, 8'h00, 8'hFF, "ctrl0_rst");
    rd(tgb_pkg::A_CTRL1, 8'h00, 8'hFF, "ctrl1_rst");
    rd(tgb_pkg::A_STAT0, 8'h20, 8'hF1, "stat0_rst");
    rd(tgb_pkg::A_TXLEN, 8'h40, 8'hFF, "txlen_rst");
    rd(tgb_pkg::A_RXLEN, 8'h00, 8'hFF, "rxlen_rst");
    rd(tgb_pkg::A_TXDAT, 8'h00, 8'hFF, "unmapped");
    // Levels are looked at away from the launching edge
    @(negedge clk);
    `CHK("int_src_rst", 1'b1, int_src)
    // Receive: 3-bit address, 10-bit data, two 1-bit fields, last overflows
    d10 = 10'($random(seed));
    rnd8 = 8'($random(seed)) & 8'hE0;
    wr(tgb_pkg::A_CTRL1, rnd8);
    wr(tgb_pkg::A_CTRL0, 8'hA0);
    NODE.play({"TTTT101T", bits(d10), "T1T0TT"});
    repeat (20) @(posedge clk);
    rd(tgb_pkg::A_TXADR, 8'hC0, 8'hC0, "state_act_hi");
    rd(tgb_pkg::A_TXADR, 8'h0F, 8'h3F, "pulse_width");
    rd(tgb_pkg::A_STAT0, 8'hF0, 8'hF1, "stat_rx");
    // Data lost is pending, so the request follows the global enable
    @(negedge clk);
    `CHK("int_req", rnd8[7], int_req)
    rd(tgb_pkg::A_RXLEN, 8'hF3, 8'hFF, "len_adr");
    rd(tgb_pkg::A_RXFLD, 8'h05, 8'hFF, "fld_adr");
    rd(tgb_pkg::A_RXLEN, 8'h40, 8'hFF, "len_d0");
    rd(tgb_pkg::A_RXFLD, d10[9:2], 8'hFF, "fld_d0");
    rd(tgb_pkg::A_RXLEN, 8'h52, 8'hFF, "len_d1");
    rd(tgb_pkg::A_RXFLD, {6'h00, d10[1:0]}, 8'hFF, "fld_d1");
    rd(tgb_pkg::A_RXLEN, 8'h51, 8'hFF, "len_one");
    rd(tgb_pkg::A_RXFLD, 8'h01, 8'hFF, "fld_one");
    rd(tgb_pkg::A_RXLEN, 8'h00, 8'hFF, "len_empty");
    repeat (500) @(posedge clk);
    rd(tgb_pkg::A_TXADR, 8'h40, 8'hC0, "state_pas_hi");
    // Transmit queue: flush, fill, run cleared
    wr(tgb_pkg::A_TXDAT, 8'($random(seed)));
    wr(tgb_pkg::A_RXLEN, 8'($random(seed)));
    rd(tgb_pkg::A_TXLEN, 8'h80, 8'hC0, "busy_set");
    wr(tgb_pkg::A_TXLEN, 8'h40);
    rd(tgb_pkg::A_TXLEN, 8'h40, 8'h40, "flush_empty");
    rd(tgb_pkg::A_STAT0, 8'h20, 8'h30, "flush_tgv");
    for (int i = 0; i < 4; i++) wr(i == 0 ? tgb_pkg::A_TXADR : tgb_pkg::A_RXFLD, 8'($random(seed)));
    wr(tgb_pkg::A_STAT0, 8'h05);
    rd(tgb_pkg::A_STAT0, 8'h00, 8'hF8, "tx_full");
    @(negedge clk);
    `CHK("int_src_off", 1'b0, int_src)
    wr(tgb_pkg::A_CTRL0, 8'h20);
    rd(tgb_pkg::A_TXLEN, 8'h40, 8'hC0, "run_clr");
    rd(tgb_pkg::A_CTRL1, rnd8, 8'hFF, "ctrl1_kept");
    // Arbitration loss on a one-bit address field
    wr(tgb_pkg::A_CTRL0, 8'hA0);
    rd(tgb_pkg::A_CTRL1, rnd8, 8'hFF, "ctrl1_run");
    wr(tgb_pkg::A_TXLEN, 8'h01);
    wr(tgb_pkg::A_TXADR, 8'h01);
    rd(tgb_pkg::A_TXLEN, 8'h80, 8'hC0, "tx_busy");
    NODE.play("TTTT0TT");
    repeat (20) @(posedge clk);
    rd(tgb_pkg::A_STAT0, 8'h71, 8'hF1, "arb_set");
    rd(tgb_pkg::A_TXLEN, 8'h40, 8'hC0, "arb_flush");
    wr(tgb_pkg::A_TXDAT, 8'hFF);
    rd(tgb_pkg::A_TXLEN, 8'h40, 8'hC0, "arb_refuse");
    rd(tgb_pkg::A_RXLEN, 8'h71, 8'hFF, "len_lost");
    rd(tgb_pkg::A_RXFLD, 8'h00, 8'hFF, "fld_lost");
    wr(tgb_pkg::A_STAT0, 8'h1E);
    rd(tgb_pkg::A_STAT0, 8'h10, 8'h11, "arb_clr");
    // Clock master T stream
    wr(tgb_pkg::A_CTRL1, 8'h00);
    wr(tgb_pkg::A_CTRL0, 8'hC0);
    wait_oe(1'b1, lo);
    wait_oe(1'b0, lo);
    wait_oe(1'b1, lo);
    wait_oe(1'b0, per);
    `CHK("t_low", 36, lo)
    `CHK("t_period", 1'b1, (lo + per >= 256 && lo + per <= 272))
    // Standby clears everything but the read data register
    standby <= 1'b1;
    repeat (2) @(posedge clk);
    standby <= 1'b0;
    rd(tgb_pkg::A_CTRL0, 8'h00, 8'hFF, "stby_ctrl0");
    rd(tgb_pkg::A_TXLEN, 8'h40, 8'hFF, "stby_txlen");
    repeat (3) @(posedge clk);
    results();
  end
endmodule
`default_nettype wire
